// [cam_settings.sv]
// Camera settings store, apply timing, mirror path and serial receiver
module cam_settings (
  // Clock, reset, clock enable
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic CE,
  // AXI4-Lite write address and data
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Frame timing from the sensor sequencer
  input wire logic FRAME_REQ,
  input wire logic EXPO_START,
  // Applied settings
  output logic MIRROR_ACT,
  output logic TEST_ACT,
  output logic TRIG_MODE_ACT,
  output logic [10:0] LINK_BW_CAP,
  output logic [23:0] EXPO_TIME,
  // Serial configuration line
  input wire logic SER_RX,
  // Pixel stream in and out
  input wire logic [7:0] PIX_IN,
  input wire logic PIX_IN_VALID,
  input wire logic PIX_IN_LAST,
  output logic PIX_IN_READY,
  output logic [7:0] PIX_OUT,
  output logic PIX_OUT_VALID,
  output logic PIX_OUT_LAST
);

  // Merge a write word into a register under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Hold the bandwidth cap at or below its ceiling
  function automatic logic [31:0] clamp_cap(input logic [31:0] d);
    logic [31:0] r;
    r = d;
    if (d[cam_cfg_pkg::CAP_LSB +: cam_cfg_pkg::CAP_W] > cam_cfg_pkg::CAP_MAX)
    begin
      r[cam_cfg_pkg::CAP_LSB +: cam_cfg_pkg::CAP_W] = cam_cfg_pkg::CAP_MAX;
    end
    return r;
  endfunction

  // Valid slot code check, shared by selector and boot register
  function automatic logic slot_ok(input logic [1:0] s);
    return s != 2'b11;
  endfunction

  // Bus state
  logic aw_have_r;           // Write address held
  logic w_have_r;            // Write data held
  logic [7:0] aw_addr_r;     // Held write address
  logic [31:0] w_data_r;     // Held write data
  logic [3:0] w_strb_r;      // Held byte enables

  // Settings state
  logic [1:0] slot_sel_r;    // Selected slot
  logic [1:0] boot_slot_r;   // Slot applied after reset
  logic [1:0] last_slot_r;   // Slot most recently loaded
  logic [31:0] work_misc_r;  // Working settings, pending
  logic [23:0] work_expo_r;  // Working exposure, pending
  logic misc_pend_r;         // Working misc written or loaded, not yet applied
  logic expo_pend_r;         // Working exposure not yet applied
  logic [31:0] label_r [0:15];  // User label storage
  logic frame_d_r;           // Frame request delayed for edge detect
  logic soft_rst_r;          // Restart pulse
  cam_cfg_pkg::seq_t st_r;

  // Serial receiver state
  logic rx_busy_r;
  logic [4:0] rx_cnt_r;
  logic [3:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic [7:0] ser_data_r;
  logic ser_full_r;
  logic ser_ferr_r;

  // Write decode
  wire logic wr_fire = aw_have_r && w_have_r && !S_AXI_BVALID;
  wire logic wr_ctrl = wr_fire && (aw_addr_r == cam_cfg_pkg::OFS_CTRL);
  wire logic wr_boot = wr_fire && (aw_addr_r == cam_cfg_pkg::OFS_BOOT);
  wire logic wr_misc = wr_fire && (aw_addr_r == cam_cfg_pkg::OFS_MISC);
  wire logic wr_expo = wr_fire && (aw_addr_r == cam_cfg_pkg::OFS_EXPO);
  wire logic wr_label = wr_fire && (aw_addr_r[7:6] == 2'b01);
  wire logic [3:0] wr_lidx = aw_addr_r[5:2];
  wire logic wr_rw = wr_ctrl || wr_boot || wr_misc || wr_expo || wr_label;
  wire logic wr_ok = wr_rw && (aw_addr_r[1:0] == 2'b00);
  wire logic cmd_load = wr_ctrl && w_strb_r[0] &&
                        w_data_r[cam_cfg_pkg::CTRL_LOAD_BIT];
  wire logic cmd_save = wr_ctrl && w_strb_r[0] &&
                        w_data_r[cam_cfg_pkg::CTRL_SAVE_BIT];
  wire logic cmd_restart = wr_ctrl && w_strb_r[1] &&
                           w_data_r[cam_cfg_pkg::CTRL_RESTART_BIT];
  wire logic [31:0] misc_wr = clamp_cap(merge(work_misc_r, w_data_r,
                                              w_strb_r));
  wire logic [31:0] expo_wr = merge({8'h00, work_expo_r}, w_data_r,
                                    w_strb_r);

  // Read decode
  wire logic rd_take = S_AXI_ARVALID && S_AXI_ARREADY;
  wire logic rd_label = (S_AXI_ARADDR[7:6] == 2'b01);
  wire logic rd_ser = rd_take && (S_AXI_ARADDR == cam_cfg_pkg::OFS_SER);
  wire logic [31:0] stat_word = {26'h0, last_slot_r, 1'b0,
                                 (st_r == cam_cfg_pkg::ST_BOOT),
                                 expo_pend_r, misc_pend_r};
  wire logic [31:0] ser_word = {22'h0, ser_ferr_r, ser_full_r, ser_data_r};
  logic [31:0] rd_word;
  logic rd_hit;

  // Slot store access
  wire logic [1:0] store_sel = (st_r == cam_cfg_pkg::ST_BOOT) ?
                               boot_slot_r : slot_sel_r;
  wire logic [55:0] slot_rd;
  wire logic frame_rise = FRAME_REQ && !frame_d_r;
  wire logic mirror_on = MIRROR_ACT && !TEST_ACT;

  // Read multiplexer
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (S_AXI_ARADDR[1:0] != 2'b00) begin
      rd_hit = 1'b0;
    end else if (rd_label) begin
      rd_word = label_r[S_AXI_ARADDR[5:2]];
    end else begin
      case (S_AXI_ARADDR)
        cam_cfg_pkg::OFS_CTRL: rd_word = {30'h0, slot_sel_r};
        cam_cfg_pkg::OFS_BOOT: rd_word = {30'h0, boot_slot_r};
        cam_cfg_pkg::OFS_MISC: rd_word = work_misc_r;
        cam_cfg_pkg::OFS_EXPO: rd_word = {8'h00, work_expo_r};
        cam_cfg_pkg::OFS_ACT_MISC: rd_word = {5'h00, LINK_BW_CAP, 13'h0000,
                                              TRIG_MODE_ACT, TEST_ACT,
                                              MIRROR_ACT};
        cam_cfg_pkg::OFS_ACT_EXPO: rd_word = {8'h00, EXPO_TIME};
        cam_cfg_pkg::OFS_STAT: rd_word = stat_word;
        cam_cfg_pkg::OFS_SER: rd_word = ser_word;
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // Write channels; address and data are taken in either order
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= cam_cfg_pkg::RESP_OKAY;
    end else if (CE) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      // Unmapped or misaligned addresses get a slave error
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_ok ? cam_cfg_pkg::RESP_OKAY :
                               cam_cfg_pkg::RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // Read channel; one read at a time
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= cam_cfg_pkg::RESP_OKAY;
    end else if (CE) begin
      if (rd_take) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_word;
        S_AXI_RRESP <= rd_hit ? cam_cfg_pkg::RESP_OKAY :
                                cam_cfg_pkg::RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  // Stored choices; these survive the restart command like flash would
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      slot_sel_r <= cam_cfg_pkg::SLOT_DEFAULT;
      boot_slot_r <= cam_cfg_pkg::SLOT_DEFAULT;
    end else if (CE) begin
      if (wr_ctrl && w_strb_r[0] && slot_ok(w_data_r[1:0])) begin
        slot_sel_r <= w_data_r[1:0];
      end
      if (wr_boot && w_strb_r[0] && slot_ok(w_data_r[1:0])) begin
        boot_slot_r <= w_data_r[1:0];
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < cam_cfg_pkg::LABEL_WORDS; i++) begin
        label_r[i] <= 32'h0000_0000;
      end
    end else if (CE && wr_label && wr_ok) begin
      label_r[wr_lidx] <= merge(label_r[wr_lidx], w_data_r, w_strb_r);
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      soft_rst_r <= 1'b0;
    end else if (CE) begin
      soft_rst_r <= cmd_restart;
    end
  end

  // Working settings: boot load, slot load, bus writes
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r <= cam_cfg_pkg::ST_BOOT;
      work_misc_r <= cam_cfg_pkg::MISC_RST;
      work_expo_r <= cam_cfg_pkg::EXPO_RST;
      misc_pend_r <= 1'b0;
      expo_pend_r <= 1'b0;
      last_slot_r <= cam_cfg_pkg::SLOT_DEFAULT;
    end else if (CE) begin
      if (soft_rst_r) begin
        st_r <= cam_cfg_pkg::ST_BOOT;
        misc_pend_r <= 1'b0;
        expo_pend_r <= 1'b0;
      end else begin
        case (st_r)
          cam_cfg_pkg::ST_BOOT: begin
            work_misc_r <= slot_rd[31:0];
            work_expo_r <= slot_rd[55:32];
            last_slot_r <= boot_slot_r;
            st_r <= cam_cfg_pkg::ST_RUN;
          end
          cam_cfg_pkg::ST_RUN: begin
            // Pending flags: a new change wins over the apply clearing them
            if (frame_rise) begin
              misc_pend_r <= 1'b0;
            end
            if (EXPO_START) begin
              expo_pend_r <= 1'b0;
            end
            if (cmd_load) begin
              work_misc_r <= slot_rd[31:0];
              work_expo_r <= slot_rd[55:32];
              last_slot_r <= slot_sel_r;
              misc_pend_r <= 1'b1;
              expo_pend_r <= 1'b1;
            end
            if (wr_misc) begin
              work_misc_r <= misc_wr;
              misc_pend_r <= 1'b1;
            end
            if (wr_expo) begin
              work_expo_r <= expo_wr[23:0];
              expo_pend_r <= 1'b1;
            end
          end
          default: st_r <= cam_cfg_pkg::ST_BOOT;
        endcase
      end
    end
  end

  // Applied settings seen by the imaging pipeline
  // free run lag tolerated
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      frame_d_r <= 1'b0;
      MIRROR_ACT <= 1'b0;
      TEST_ACT <= 1'b0;
      TRIG_MODE_ACT <= 1'b0;
      LINK_BW_CAP <= cam_cfg_pkg::CAP_MAX;
      EXPO_TIME <= cam_cfg_pkg::EXPO_RST;
    end else if (CE) begin
      frame_d_r <= FRAME_REQ;
      if (st_r == cam_cfg_pkg::ST_BOOT && !soft_rst_r) begin
        // Nothing is running yet, so the boot slot goes live at once
        MIRROR_ACT <= slot_rd[cam_cfg_pkg::MIRROR_BIT];
        TEST_ACT <= slot_rd[cam_cfg_pkg::TEST_BIT];
        TRIG_MODE_ACT <= slot_rd[cam_cfg_pkg::TRIG_BIT];
        LINK_BW_CAP <= slot_rd[cam_cfg_pkg::CAP_LSB +: cam_cfg_pkg::CAP_W];
        EXPO_TIME <= slot_rd[55:32];
      end else begin
        if (frame_rise) begin
          MIRROR_ACT <= work_misc_r[cam_cfg_pkg::MIRROR_BIT];
          TEST_ACT <= work_misc_r[cam_cfg_pkg::TEST_BIT];
          TRIG_MODE_ACT <= work_misc_r[cam_cfg_pkg::TRIG_BIT];
          LINK_BW_CAP <= work_misc_r[cam_cfg_pkg::CAP_LSB +:
                                     cam_cfg_pkg::CAP_W];
        end
        if (EXPO_START) begin
          EXPO_TIME <= work_expo_r;
        end
      end
    end
  end

  // 8N1 receiver, no flow control
  // Sampled mid-bit; a low stop bit flags a framing error
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rx_busy_r <= 1'b0;
      rx_cnt_r <= 5'h00;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 8'h00;
      ser_data_r <= 8'h00;
      ser_full_r <= 1'b0;
      ser_ferr_r <= 1'b0;
    end else if (CE) begin
      // Reading the data register empties it; a new byte wins
      if (rd_ser) begin
        ser_full_r <= 1'b0;
        ser_ferr_r <= 1'b0;
      end
      if (soft_rst_r) begin
        rx_busy_r <= 1'b0;
      end else if (!rx_busy_r) begin
        if (!SER_RX) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r <= 5'(cam_cfg_pkg::HALF_CYC);
          rx_bit_r <= 4'h0;
        end
      end else if (rx_cnt_r != 5'h00) begin
        rx_cnt_r <= rx_cnt_r - 5'h01;
      end else begin
        rx_cnt_r <= 5'(cam_cfg_pkg::BIT_CYC - 1);
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0 && SER_RX) begin
          rx_busy_r <= 1'b0;
        end else if (rx_bit_r == 4'(cam_cfg_pkg::SER_BITS + 1)) begin
          rx_busy_r <= 1'b0;
          ser_data_r <= rx_sh_r;
          ser_full_r <= 1'b1;
          ser_ferr_r <= !SER_RX;
        end else if (rx_bit_r != 4'h0) begin
          rx_sh_r <= {SER_RX, rx_sh_r[7:1]};
        end
      end
    end
  end

  // Settings slots
  // save working to user slot
  slot_store u_store (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .ce(CE),
    .save_en(cmd_save && st_r == cam_cfg_pkg::ST_RUN),
    .sel(store_sel),
    .wr_set({work_expo_r, work_misc_r}),
    .rd_set(slot_rd)
  );

  line_mirror u_mirror (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .ce(CE),
    .mirror_en(mirror_on),
    .in_data(PIX_IN),
    .in_valid(PIX_IN_VALID),
    .in_last(PIX_IN_LAST),
    .in_ready(PIX_IN_READY),
    .out_data(PIX_OUT),
    .out_valid(PIX_OUT_VALID),
    .out_last(PIX_OUT_LAST)
  );

endmodule

// [cam_cfg_pkg.sv]
// Shared constants and types for the camera settings store and apply block
package cam_cfg_pkg;

  // Register map, byte addresses on the AXI4-Lite bus
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BOOT = 8'h04;
  localparam logic [7:0] OFS_MISC = 8'h08;
  localparam logic [7:0] OFS_EXPO = 8'h0c;
  localparam logic [7:0] OFS_ACT_MISC = 8'h10;
  localparam logic [7:0] OFS_ACT_EXPO = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_SER = 8'h1c;
  localparam logic [7:0] OFS_LABEL = 8'h40;
  localparam int LABEL_WORDS = 16;

  // Control register command bits
  localparam int CTRL_LOAD_BIT = 4;
  localparam int CTRL_SAVE_BIT = 5;
  localparam int CTRL_RESTART_BIT = 8;

  // Working settings word layout
  localparam int MIRROR_BIT = 0;
  localparam int TEST_BIT = 1;
  localparam int TRIG_BIT = 2;
  localparam int CAP_LSB = 16;
  localparam int CAP_W = 11;
  localparam logic [10:0] CAP_MAX = 11'h6a4;
  localparam int EXPO_W = 24;
  localparam int SET_W = 32 + EXPO_W;

  // Values after reset and the factory default slot contents
  localparam logic [31:0] MISC_RST = 32'h06a4_0000;
  localparam logic [23:0] EXPO_RST = 24'h002710;
  localparam logic [55:0] FACTORY_SET = {EXPO_RST, MISC_RST};

  // Serial link framing: 8 data bits, no parity, one stop bit
  localparam int CLK_HZ = 25000000;
  localparam int BAUD_BPS = 1152200;
  localparam int BIT_CYC = CLK_HZ / BAUD_BPS;
  localparam int HALF_CYC = BIT_CYC / 2;
  localparam int SER_BITS = 8;

  // Mirror line buffer
  localparam int PIX_W = 8;
  localparam int LINE_MAX = 16;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Settings slots
  typedef enum logic [1:0] {
    SLOT_DEFAULT = 2'b00,
    SLOT_USER1 = 2'b01,
    SLOT_USER2 = 2'b10
  } slot_t;

  // Top sequencer states
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_RUN = 2'b01
  } seq_t;

  // Line buffer states
  typedef enum logic [1:0] {
    MS_FILL = 2'b00,
    MS_DRAIN = 2'b01
  } mir_t;

endpackage

// [slot_store.sv]
// Non-volatile settings slots: factory default plus two user slots
module slot_store (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Save request and slot choice
  input wire logic save_en,
  input wire logic [1:0] sel,
  input wire logic [55:0] wr_set,
  // Contents of the chosen slot
  output logic [55:0] rd_set
);

  // User slot storage, indexed by slot number minus one
  logic [55:0] user_r [0:1];

  // Index of the user slot named by sel
  wire logic idx = (sel == cam_cfg_pkg::SLOT_USER2);
  wire logic is_user = (sel == cam_cfg_pkg::SLOT_USER1) ||
                       (sel == cam_cfg_pkg::SLOT_USER2);

  // save to default ignored
  // Only power-on reset clears slots; the restart command never reaches them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      user_r[0] <= cam_cfg_pkg::FACTORY_SET;
      user_r[1] <= cam_cfg_pkg::FACTORY_SET;
    end else if (ce && save_en && is_user) begin
      user_r[idx] <= wr_set;
    end
  end

  assign rd_set = is_user ? user_r[idx] : cam_cfg_pkg::FACTORY_SET;

endmodule

// [line_mirror.sv]
// Line buffer that emits each line in forward or reversed pixel order
module line_mirror (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic mirror_en,
  // Incoming line
  input wire logic [7:0] in_data,
  input wire logic in_valid,
  input wire logic in_last,
  output logic in_ready,
  // Outgoing line
  output logic [7:0] out_data,
  output logic out_valid,
  output logic out_last
);

  logic [7:0] mem_r [0:15];  // Pixel storage for one line
  logic [3:0] wr_idx_r;      // Next write position
  logic [3:0] rd_idx_r;      // Next read position
  logic [3:0] end_idx_r;     // Read position of the final pixel
  logic rev_r;               // Direction latched for the whole line
  cam_cfg_pkg::mir_t st_r;

  wire logic take = in_valid && in_ready;
  wire logic line_done = in_last || (wr_idx_r == 4'(cam_cfg_pkg::LINE_MAX - 1));
  wire logic [3:0] rd_step = rev_r ? rd_idx_r - 4'h1 : rd_idx_r + 4'h1;

  // Store pixels into the buffer
  always_ff @(posedge clk) begin
    if (ce && take) begin
      mem_r[wr_idx_r] <= in_data;
    end
  end

  // Fill then drain; input stalls while a line drains
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= cam_cfg_pkg::MS_FILL;
      wr_idx_r <= 4'h0;
      rd_idx_r <= 4'h0;
      end_idx_r <= 4'h0;
      rev_r <= 1'b0;
      in_ready <= 1'b1;
      out_data <= 8'h00;
      out_valid <= 1'b0;
      out_last <= 1'b0;
    end else if (ce) begin
      case (st_r)
        cam_cfg_pkg::MS_FILL: begin
          out_valid <= 1'b0;
          out_last <= 1'b0;
          if (take && line_done) begin
            rev_r <= mirror_en;
            rd_idx_r <= mirror_en ? wr_idx_r : 4'h0;
            end_idx_r <= mirror_en ? 4'h0 : wr_idx_r;
            wr_idx_r <= 4'h0;
            in_ready <= 1'b0;
            st_r <= cam_cfg_pkg::MS_DRAIN;
          end else if (take) begin
            wr_idx_r <= wr_idx_r + 4'h1;
          end
        end
        cam_cfg_pkg::MS_DRAIN: begin
          out_valid <= 1'b1;
          out_data <= mem_r[rd_idx_r];
          out_last <= (rd_idx_r == end_idx_r);
          rd_idx_r <= rd_step;
          if (rd_idx_r == end_idx_r) begin
            in_ready <= 1'b1;
            st_r <= cam_cfg_pkg::MS_FILL;
          end
        end
        default: begin
          st_r <= cam_cfg_pkg::MS_FILL;
          in_ready <= 1'b1;
        end
      endcase
    end
  end

endmodule

// [cam_settings_assertions.sv]
// Port-level assertions for the camera settings block
module cam_settings_chk (
  // Clock, reset, enable
  input logic SYS_CLK, RST_B, CE,
  // Frame timing and applied settings
  input logic FRAME_REQ, EXPO_START, MIRROR_ACT, TEST_ACT,
  input logic [10:0] LINK_BW_CAP,
  input logic [23:0] EXPO_TIME,
  // Bus handshakes
  input logic S_AXI_AWREADY, S_AXI_BVALID, S_AXI_BREADY,
  input logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  a_misc_apply:
  assert property ($changed({MIRROR_ACT, TEST_ACT, LINK_BW_CAP}) |->
    $past(FRAME_REQ) && !$past(FRAME_REQ, 2))
    else $error("applied misc moved without frame request");
  a_expo_apply:
  assert property ($changed(EXPO_TIME) |-> $past(EXPO_START))
    else $error("exposure moved without exposure start");
  a_cap_limit:
  assert property (LINK_BW_CAP <= 11'h6a4)
    else $error("bandwidth cap above maximum");
  a_rd_latency:
  assert property (S_AXI_ARVALID && S_AXI_ARREADY && CE |=> S_AXI_RVALID)
    else $error("read answer late");
  a_rd_busy:
  assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address ready while answer pending");
  a_rd_done:
  assert property (S_AXI_RVALID && S_AXI_RREADY && CE |=>
    !S_AXI_RVALID && S_AXI_ARREADY)
    else $error("read answer not retired");
  a_wr_busy:
  assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
    else $error("write address ready while response pending");
  a_wr_done:
  assert property (S_AXI_BVALID && S_AXI_BREADY && CE |=>
    !S_AXI_BVALID && S_AXI_AWREADY)
    else $error("write response not retired");
endmodule
bind cam_settings cam_settings_chk chk (.*);

// [host_uart.sv]
// Host side model: sends bytes on the serial configuration line
module host_uart (
  // Clock and serial line
  input wire logic clk,
  output logic tx
);
  timeunit 1ns;
  timeprecision 1ns;
  // Line idles high between frames
  initial tx = 1'b1;
  // start, eight data lsb first, one stop
  task send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      tx <= f[i];
      repeat (cam_cfg_pkg::BIT_CYC) @(posedge clk);
    end
  endtask
endmodule

// [camera_settings_store_apply_tb.sv]
// Self-checking bench for the camera settings block
module camera_settings_store_apply_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Signals named after the block's ports
  logic SYS_CLK, RST_B, CE, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID;
  logic S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID;
  logic S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, FRAME_REQ, EXPO_START;
  logic MIRROR_ACT, TEST_ACT, TRIG_MODE_ACT, SER_RX, PIX_IN_VALID;
  logic PIX_IN_LAST, PIX_IN_READY, PIX_OUT_VALID, PIX_OUT_LAST;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR, PIX_IN, PIX_OUT;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
  logic [10:0] LINK_BW_CAP;
  logic [23:0] EXPO_TIME;
  int error_cnt = 0;
  int n_compared = 0;
  cam_settings uut (.*);
  host_uart hu (.clk(SYS_CLK), .tx(SER_RX));
  // 25 MHz clock
  initial begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  // Compare and count
  task ck(input logic [31:0] s, e, input string n);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // One write; address and data offered together, each dropped when taken
  task wr(input logic [7:0] a, input logic [31:0] v,
          input logic [3:0] s = 4'hf);
    @(posedge SYS_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    S_AXI_WSTRB <= s;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    do begin
      @(posedge SYS_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (!S_AXI_BVALID);
    S_AXI_BREADY <= 1'b0;
    ck(S_AXI_BRESP, cam_cfg_pkg::RESP_OKAY, "bresp");
  endtask
  // One read; word and response kept in d and r
  task rd(input logic [7:0] a);
    @(posedge SYS_CLK);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    do begin
      @(posedge SYS_CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!S_AXI_RVALID);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e, input string n);
    rd(a);
    ck(d, e, n);
  endtask
  // Frame request and exposure start pulses, then let updates land
  task fr;
    @(posedge SYS_CLK) FRAME_REQ <= 1'b1;
    @(posedge SYS_CLK) FRAME_REQ <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task es;
    @(posedge SYS_CLK) EXPO_START <= 1'b1;
    @(posedge SYS_CLK) EXPO_START <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  // Label word round trip and an unmapped hole
  task t_label;
    wr(8'h7c, 32'hc0de_5a11);
    rc(8'h7c, 32'hc0de_5a11, "label");
    rd(8'h20);
    ck(r, cam_cfg_pkg::RESP_SLVERR, "hole");
  endtask
  // Pending settings go live only at their own timing events
  task t_apply;
    wr(cam_cfg_pkg::OFS_MISC, 32'h07ff_0001);
    wr(cam_cfg_pkg::OFS_EXPO, 32'h0000_0123);
    ck(MIRROR_ACT, 1'b0, "mirror early");
    // changes written before the frame request
    fr();
    ck(MIRROR_ACT, 1'b1, "mirror");
    ck(LINK_BW_CAP, 11'h6a4, "cap");
    ck(EXPO_TIME, 24'h002710, "expo at frame");
    es();
    ck(EXPO_TIME, 24'h000123, "expo");
    rc(cam_cfg_pkg::OFS_MISC, 32'h06a4_0001, "cap clamp");
  endtask
  // Save, save on default, load, then boot slot through restart
  task t_slots;
    wr(cam_cfg_pkg::OFS_CTRL, 32'h1);
    wr(cam_cfg_pkg::OFS_CTRL, 32'h21);
    wr(cam_cfg_pkg::OFS_MISC, 32'h0);
    wr(cam_cfg_pkg::OFS_CTRL, 32'h0);
    wr(cam_cfg_pkg::OFS_CTRL, 32'h20);
    wr(cam_cfg_pkg::OFS_CTRL, 32'h10);
    rc(cam_cfg_pkg::OFS_MISC, 32'h06a4_0000, "default");
    rc(cam_cfg_pkg::OFS_EXPO, 32'h2710, "default expo");
    wr(cam_cfg_pkg::OFS_CTRL, 32'h1);
    wr(cam_cfg_pkg::OFS_CTRL, 32'h11);
    rc(cam_cfg_pkg::OFS_MISC, 32'h06a4_0001, "user1");
    wr(cam_cfg_pkg::OFS_MISC, 32'h0);
    wr(cam_cfg_pkg::OFS_BOOT, 32'h1);
    wr(cam_cfg_pkg::OFS_CTRL, 32'h100, 4'h2);
    repeat (4) @(posedge SYS_CLK);
    rc(cam_cfg_pkg::OFS_MISC, 32'h06a4_0001, "boot");
    rc(cam_cfg_pkg::OFS_EXPO, 32'h123, "boot expo");
  endtask
  // One byte over the serial line
  task t_serial;
    hu.send(8'h5a);
    rc(cam_cfg_pkg::OFS_SER, 32'h15a, "serial");
  endtask
  // Three-pixel line; e holds the pixels expected out, first in top byte
  task t_line(input logic [23:0] e);
    for (int i = 1; i < 4; i++) begin
      {PIX_IN_VALID, PIX_IN_LAST, PIX_IN} <= {1'b1, i == 3, 8'(i)};
      @(posedge SYS_CLK);
    end
    PIX_IN_VALID <= 1'b0;
    @(posedge SYS_CLK);
    for (int i = 2; i >= 0; i--) begin
      @(posedge SYS_CLK);
      ck({PIX_OUT_VALID, PIX_OUT_LAST, PIX_OUT}, {1'b1, i == 0, e[8*i +: 8]},
         "pixel");
    end
    ck(PIX_IN_READY, 1'b1, "ready");
  endtask
  // Mirror reverses a line; a test image turns mirroring off
  task t_mirror;
    t_line(24'h030201);
    wr(cam_cfg_pkg::OFS_MISC, 32'h06a4_0007);
    fr();
    ck(TEST_ACT, 1'b1, "test");
    ck(TRIG_MODE_ACT, 1'b1, "trigger");
    t_line(24'h010203);
  endtask
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard, well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    error_cnt++;
    summarize();
  end
  // Reset for two cycles, then the scenarios
  initial begin
    {RST_B, CE, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 5'h08;
    {S_AXI_ARVALID, S_AXI_RREADY, FRAME_REQ, EXPO_START} = 4'h0;
    {PIX_IN_VALID, PIX_IN_LAST, PIX_IN, S_AXI_AWADDR} = '0;
    {S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = '0;
    repeat (2) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    t_label();
    t_apply();
    t_slots();
    t_serial();
    t_mirror();
    summarize();
  end
endmodule
